// *** rtl/clsp_defs.svh ***
// Register offsets, field positions, reset values and divider counts of the clocked serial port.
`ifndef CLSP_DEFS_SVH
`define CLSP_DEFS_SVH

`define CLSP_CTRL_OFFSET  8'h0A
`define CLSP_DATA_OFFSET  8'h0B

`define CLSP_END_BIT      7
`define CLSP_IEN_BIT      6
`define CLSP_RX_BIT       5
`define CLSP_TX_BIT       4
`define CLSP_SS_MSB       2
`define CLSP_SS_LSB       0

`define CLSP_CTRL_RESET   8'h07
`define CLSP_SS_RESET     3'h7
`define CLSP_SS_EXTERNAL  3'h7

`define CLSP_BASE_DIV     11'h014
`define CLSP_HALF_BASE    10'h00A
`define CLSP_LAST_BIT     3'h7
`define CLSP_START_WAIT   700

`endif

// *** rtl/clsp_pkg.sv ***
// Types shared by the clocked serial port modules.
package clsp_pkg;

    typedef enum logic [1:0] {
        CLSP_IDLE,
        CLSP_LOW,
        CLSP_HIGH,
        CLSP_EXT
    } clsp_state_type;

endpackage

// *** rtl/clsp_link_if.sv ***
// Carrier between the register side and the link-clock shifter.
`timescale 1ns/1ns
interface clsp_link_if;
    logic       link_clear;
    logic [7:0] tx_word;
    logic [7:0] rx_word;
    logic       byte_done;
    logic       tx_bit;

    modport core (
        output link_clear,
        output tx_word,
        input  rx_word,
        input  byte_done,
        input  tx_bit
    );

    modport link (
        input  link_clear,
        input  tx_word,
        output rx_word,
        output byte_done,
        output tx_bit
    );
endinterface

// *** rtl/clsp_link_shifter.sv ***
// Shifter that runs on the externally supplied serial clock.
`timescale 1ns/1ns
`include "clsp_defs.svh"
module clsp_link_shifter
    import clsp_pkg::*;
(
    input  wire logic       link_clk,
    input  wire logic       rx_pin,
    clsp_link_if.link       lnk
);

    logic [2:0] rise_cnt;
    logic [2:0] fall_cnt;
    logic [7:0] rx_shift;
    logic       done;

    // The far clock may stop dead after the last bit, so the register side holds this
    // logic cleared between frames instead of counting on trailing edges.
    always_ff @(posedge link_clk or posedge lnk.link_clear) begin
        if (lnk.link_clear) begin
            rise_cnt <= 3'h0;
            done     <= 1'b0;
        end else begin
            rise_cnt <= rise_cnt + 3'h1;
            if (rise_cnt == `CLSP_LAST_BIT) begin
                done <= 1'b1;
            end
        end
    end

    always_ff @(negedge link_clk or posedge lnk.link_clear) begin
        if (lnk.link_clear) begin
            fall_cnt <= 3'h0;
        end else begin
            fall_cnt <= fall_cnt + 3'h1;
        end
    end

    always_ff @(posedge link_clk) begin
        rx_shift <= {rx_shift[6:0], rx_pin};
    end

    assign lnk.tx_bit    = lnk.tx_word[`CLSP_LAST_BIT - fall_cnt];
    assign lnk.rx_word   = rx_shift;
    assign lnk.byte_done = done;

    // Checked on falling edges: at the seventh falling edge the rising count stands one ahead and the byte is not yet done.
    property p_link_done_eighth;
        @(negedge link_clk) disable iff (lnk.link_clear)
        (rise_cnt == `CLSP_LAST_BIT) |-> (fall_cnt == 3'h6) && !done;
    endproperty
    a_link_done_eighth: assert property (p_link_done_eighth) else $error("link edge counts out of step");

    property p_link_no_early_done;
        @(negedge link_clk) disable iff (lnk.link_clear)
        (rise_cnt != 3'h0) |-> !done;
    endproperty
    a_link_no_early_done: assert property (p_link_no_early_done) else $error("link byte done too early");

    c_link_byte: cover property (@(posedge link_clk) disable iff (lnk.link_clear) rise_cnt == `CLSP_LAST_BIT);

endmodule

// *** rtl/clsp_top.sv ***
// Clocked serial port: processor registers, internal shift engine and external clock hand-off.
`timescale 1ns/1ns
`include "clsp_defs.svh"
// Summary of operation
// - Half-duplex fixed bytes, internal or external clock.
// - Finished byte sets the end flag.
// - Interrupt request is end flag and enable.
// - Data register access clears the end flag.
// - Reset clears flags and starts, selects external.
// - Halt mode clears end flag and starts.
// - Receive start bit begins receive, enables clock.
// - Internal clock driven out, external taken in.
// - Receive samples eight bits, then flags completion.
// - Transmit start shifts eight bits, then completes.
// - Receive and transmit starts never both set.
// - Speed select picks clock source and rate.
// - Single data register; writes corrupt running transmit.
// - Non-external select drives clock pin at all times, low while idle.
// - Clearing a start bit aborts its transfer.
// - Reset aborts transfer, keeps data register contents.
module clsp_top
    import clsp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       io_halt_mode,
    input  wire logic [7:0] cpu_addr,
    input  wire logic       cpu_wr,
    input  wire logic       cpu_rd,
    input  wire logic [7:0] cpu_wdata,
    output logic      [7:0] cpu_rdata,
    output logic            cpu_irq,
    input  wire logic       serial_clock_pin_in,
    output logic            serial_clock_pin_out,
    output logic            serial_clock_pin_oe,
    output logic            serial_tx_pin,
    input  wire logic       serial_rx_pin
);

    logic           end_flag;
    logic           end_irq_enable;
    logic           rx_start_bit;
    logic           tx_start_bit;
    logic [2:0]     speed_select;
    logic [7:0]     shift_data;
    clsp_state_type state;
    clsp_state_type next_state;
    logic [9:0]     half_cnt;
    logic [9:0]     next_half_cnt;
    logic [2:0]     bit_cnt;
    logic [2:0]     next_bit_cnt;
    logic           sclk_int;
    logic           next_sclk_int;
    logic           tx_int;
    logic           next_tx_int;
    logic [7:0]     next_shift_data;
    logic           xfer_done;
    logic           rx_meta;
    logic           rx_sync;
    logic           done_meta;
    logic           done_sync;
    logic           done_prev;
    logic           link_release;

    clsp_link_if lnk ();

    clsp_link_shifter u_link (
        .link_clk (serial_clock_pin_in),
        .rx_pin   (serial_rx_pin),
        .lnk      (lnk)
    );

    function automatic logic [9:0] half_period(input logic [2:0] ss);
        half_period = `CLSP_HALF_BASE << ss;
    endfunction

    logic       sel_ctrl;
    logic       sel_data;
    logic       wr_ctrl;
    logic       data_access;
    logic       ext_clk;
    logic       xfer_enabled;
    logic       half_hit;
    logic       ext_done;
    logic       shift_in_bit;
    logic [7:0] ctrl_value;
    logic [7:0] read_mux;
    logic       next_end_flag;
    logic       next_rx_start;
    logic       next_tx_start;

    assign sel_ctrl     = cpu_addr == `CLSP_CTRL_OFFSET;
    assign sel_data     = cpu_addr == `CLSP_DATA_OFFSET;
    assign wr_ctrl      = cpu_wr & sel_ctrl;
    assign data_access  = (cpu_wr | cpu_rd) & sel_data;
    assign ext_clk      = speed_select == `CLSP_SS_EXTERNAL;
    assign xfer_enabled = rx_start_bit | tx_start_bit;
    assign half_hit     = half_cnt == half_period(speed_select) - 10'h001;
    assign ext_done     = done_sync & ~done_prev;
    // An internal-clock transmit rotates the byte through itself, so the data register is intact afterwards.
    assign shift_in_bit = rx_start_bit ? rx_sync : shift_data[7];
    assign ctrl_value   = {end_flag, end_irq_enable, rx_start_bit, tx_start_bit, 1'b0, speed_select};
    assign read_mux     = sel_ctrl ? ctrl_value : (sel_data ? shift_data : 8'h00);

    // A completion in the same cycle as a data access wins, so no end event is lost.
    assign next_end_flag = io_halt_mode ? 1'b0 :
                           xfer_done    ? 1'b1 :
                           data_access  ? 1'b0 : end_flag;
    // A write asking for both directions is refused: neither start bit is taken.
    assign next_rx_start = (io_halt_mode | xfer_done) ? 1'b0 :
                           wr_ctrl ? (cpu_wdata[`CLSP_RX_BIT] & ~cpu_wdata[`CLSP_TX_BIT]) : rx_start_bit;
    assign next_tx_start = (io_halt_mode | xfer_done) ? 1'b0 :
                           wr_ctrl ? (cpu_wdata[`CLSP_TX_BIT] & ~cpu_wdata[`CLSP_RX_BIT]) : tx_start_bit;

    always_comb begin
        next_state      = state;
        next_half_cnt   = half_cnt + 10'h001;
        next_bit_cnt    = bit_cnt;
        next_sclk_int   = sclk_int;
        next_tx_int     = tx_int;
        next_shift_data = shift_data;
        xfer_done       = 1'b0;
        case (state)
            CLSP_IDLE: begin
                next_half_cnt = 10'h000;
                next_bit_cnt  = 3'h0;
                next_sclk_int = 1'b0;
                if (xfer_enabled) begin
                    next_state  = ext_clk ? CLSP_EXT : CLSP_LOW;
                    next_tx_int = shift_data[7];
                end
            end
            CLSP_LOW: begin
                if (half_hit) begin
                    next_state      = CLSP_HIGH;
                    next_half_cnt   = 10'h000;
                    next_sclk_int   = 1'b1;
                    next_shift_data = {shift_data[6:0], shift_in_bit};
                end
            end
            CLSP_HIGH: begin
                if (half_hit) begin
                    next_half_cnt = 10'h000;
                    next_sclk_int = 1'b0;
                    if (bit_cnt == `CLSP_LAST_BIT) begin
                        xfer_done  = 1'b1;
                        next_state = CLSP_IDLE;
                    end else begin
                        next_bit_cnt = bit_cnt + 3'h1;
                        next_tx_int  = shift_data[7];
                        next_state   = CLSP_LOW;
                    end
                end
            end
            CLSP_EXT: begin
                if (ext_done) begin
                    xfer_done  = 1'b1;
                    next_state = CLSP_IDLE;
                    if (rx_start_bit) begin
                        next_shift_data = lnk.rx_word;
                    end
                end
            end
            default: begin
                next_state = CLSP_IDLE;
            end
        endcase
        if (!xfer_enabled && state != CLSP_IDLE) begin
            next_state    = CLSP_IDLE;
            next_sclk_int = 1'b0;
            xfer_done     = 1'b0;
        end
        if (cpu_wr && sel_data) begin
            next_shift_data = cpu_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state    <= CLSP_IDLE;
            half_cnt <= 10'h000;
            bit_cnt  <= 3'h0;
            sclk_int <= 1'b0;
            tx_int   <= 1'b1;
        end else begin
            state    <= next_state;
            half_cnt <= next_half_cnt;
            bit_cnt  <= next_bit_cnt;
            sclk_int <= next_sclk_int;
            tx_int   <= next_tx_int;
        end
    end

    // Held while reset is low, so a reset in mid-shift leaves the byte where it stood.
    always_ff @(posedge clk) begin
        if (rst_n) begin
            shift_data <= next_shift_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            end_flag       <= 1'b0;
            end_irq_enable <= 1'b0;
            rx_start_bit   <= 1'b0;
            tx_start_bit   <= 1'b0;
            speed_select   <= `CLSP_SS_RESET;
            cpu_rdata      <= 8'h00;
        end else begin
            end_flag     <= next_end_flag;
            rx_start_bit <= next_rx_start;
            tx_start_bit <= next_tx_start;
            if (wr_ctrl) begin
                end_irq_enable <= cpu_wdata[`CLSP_IEN_BIT];
                speed_select   <= cpu_wdata[`CLSP_SS_MSB:`CLSP_SS_LSB];
            end
            if (cpu_rd) begin
                cpu_rdata <= read_mux;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_meta      <= 1'b0;
            rx_sync      <= 1'b0;
            done_meta    <= 1'b0;
            done_sync    <= 1'b0;
            done_prev    <= 1'b0;
            link_release <= 1'b0;
        end else begin
            rx_meta      <= serial_rx_pin;
            rx_sync      <= rx_meta;
            done_meta    <= lnk.byte_done;
            done_sync    <= done_meta;
            done_prev    <= done_sync;
            link_release <= next_state == CLSP_EXT;
        end
    end

    // The link side is held cleared except while an external frame is armed.
    assign lnk.link_clear       = ~link_release;
    assign lnk.tx_word          = shift_data;
    assign cpu_irq              = end_flag & end_irq_enable;
    assign serial_clock_pin_oe  = ~ext_clk;
    assign serial_clock_pin_out = sclk_int;
    assign serial_tx_pin        = ext_clk ? lnk.tx_bit : tx_int;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_irq_raise;
        ($rose(end_flag) && end_irq_enable) |-> cpu_irq ##1 (cpu_irq || !end_flag || !end_irq_enable);
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("interrupt not raised with end flag");

    property p_irq_masked;
        !end_irq_enable |-> !cpu_irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("interrupt raised while disabled");

    property p_never_both;
        !(rx_start_bit && tx_start_bit);
    endproperty
    a_never_both: assert property (p_never_both) else $error("receive and transmit both started");

    property p_access_clears;
        (data_access && !xfer_done && !io_halt_mode) |=> !end_flag;
    endproperty
    a_access_clears: assert property (p_access_clears) else $error("data access left end flag set");

    property p_done_flags;
        (xfer_done && !io_halt_mode) |=> end_flag && !rx_start_bit && !tx_start_bit;
    endproperty
    a_done_flags: assert property (p_done_flags) else $error("completion did not update flags");

    property p_halt_clears;
        io_halt_mode |=> !end_flag && !rx_start_bit && !tx_start_bit;
    endproperty
    a_halt_clears: assert property (p_halt_clears) else $error("halt mode left flags set");

    property p_reset_values;
        disable iff (1'b0) !rst_n |=> ctrl_value == `CLSP_CTRL_RESET && state == CLSP_IDLE;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("control register wrong after reset");

    property p_reset_keeps_data;
        disable iff (1'b0) (!rst_n && !(cpu_wr && sel_data)) |=> shift_data === $past(shift_data);
    endproperty
    a_reset_keeps_data: assert property (p_reset_keeps_data) else $error("reset changed data register");

    // Length of the current high phase of the internal shift clock, in system cycles.
    logic [9:0] high_run;

    always_ff @(posedge clk) begin
        if (!rst_n || !sclk_int) begin
            high_run <= 10'h000;
        end else begin
            high_run <= high_run + 10'h001;
        end
    end

    property p_clock_half;
        ($fell(serial_clock_pin_out) && $past(xfer_enabled)) |-> high_run == half_period(speed_select);
    endproperty
    a_clock_half: assert property (p_clock_half) else $error("shift clock high time wrong");

    property p_idle_clock_low;
        (state == CLSP_IDLE) |-> !serial_clock_pin_out && (serial_clock_pin_oe == (speed_select != 3'h7));
    endproperty
    a_idle_clock_low: assert property (p_idle_clock_low) else $error("clock pin wrong while idle");

    property p_start_clock;
        ($rose(xfer_enabled) && !ext_clk) |-> ##[1:`CLSP_START_WAIT] ($rose(serial_clock_pin_out) || !xfer_enabled);
    endproperty
    a_start_clock: assert property (p_start_clock) else $error("start bit did not run the clock");

    property p_abort;
        ($fell(xfer_enabled) && $past(state) != CLSP_IDLE) |=> state == CLSP_IDLE && !serial_clock_pin_out;
    endproperty
    a_abort: assert property (p_abort) else $error("cleared start bit did not abort");

    c_int_tx: cover property (xfer_done && tx_start_bit && !ext_clk);
    c_int_rx: cover property (xfer_done && rx_start_bit && !ext_clk);
    c_ext_rx: cover property (xfer_done && rx_start_bit && ext_clk);
    c_abort:  cover property ($fell(xfer_enabled) && !xfer_done && !io_halt_mode);

endmodule

// *** sim/clsp_far_end.sv ***
// Far-end peer model of the clocked serial port.
`timescale 1ns/1ns
module clsp_far_end (
    input  wire logic       clk_pin,
    input  wire logic       tx_line,
    output logic            link_clk,
    output logic            rx_line,
    output logic      [7:0] got_byte
);
    logic [7:0] out_sr;

    initial begin
        link_clk = 1'b0;
        rx_line  = 1'b1;
        out_sr   = 8'hFF;
        got_byte = 8'h00;
    end

    // The peer samples on the rising edge and changes its data on the falling edge.
    always @(posedge clk_pin) begin
        got_byte <= {got_byte[6:0], tx_line};
    end

    // Past the byte the line keeps toggling so a late sample cannot pass by luck.
    always @(negedge clk_pin) begin
        out_sr  <= {out_sr[6:0], ~out_sr[0]};
        rx_line <= out_sr[6];
    end

    task automatic load(input logic [7:0] b);
        out_sr  = b;
        rx_line = b[7];
    endtask

    // As master it makes eight pulses of 24 ns high, one every 48 ns, and holds the clock low outside the frame.
    task automatic frame();
        #5;
        repeat (8) begin
            #24 link_clk = 1'b1;
            #24 link_clk = 1'b0;
        end
    endtask
endmodule

// *** sim/tb.sv ***
// Self-checking testbench of the clocked serial port.
`timescale 1ns/1ns
`include "clsp_defs.svh"
module tb;
    logic        clk;
    logic        rst_n;
    logic        io_halt_mode;
    logic [7:0]  cpu_addr;
    logic        cpu_wr;
    logic        cpu_rd;
    logic [7:0]  cpu_wdata;
    logic [7:0]  cpu_rdata;
    logic        cpu_irq;
    logic        clk_out;
    logic        clk_oe;
    logic        tx;
    logic        rx;
    logic        link_clk;
    wire         clk_pin;
    logic [7:0]  got;
    logic [15:0] hi_cnt;
    logic [15:0] hi_len;
    int          failures;
    int          n_checks;
    int          cycle_cnt;

    assign clk_pin = clk_oe ? clk_out : link_clk;

    clsp_top clsp_top_i (
        .clk                  (clk),
        .rst_n                (rst_n),
        .io_halt_mode         (io_halt_mode),
        .cpu_addr             (cpu_addr),
        .cpu_wr               (cpu_wr),
        .cpu_rd               (cpu_rd),
        .cpu_wdata            (cpu_wdata),
        .cpu_rdata            (cpu_rdata),
        .cpu_irq              (cpu_irq),
        .serial_clock_pin_in  (clk_pin),
        .serial_clock_pin_out (clk_out),
        .serial_clock_pin_oe  (clk_oe),
        .serial_tx_pin        (tx),
        .serial_rx_pin        (rx)
    );

    clsp_far_end clsp_far_end_i (
        .clk_pin  (clk_pin),
        .tx_line  (tx),
        .link_clk (link_clk),
        .rx_line  (rx),
        .got_byte (got)
    );

    initial clk = 1'b0;
    always #4 clk = ~clk;

    // Length of the last high phase of the internal shift clock, in system cycles.
    always @(posedge clk) begin
        if (clk_out === 1'b1) begin
            hi_cnt <= hi_cnt + 16'd1;
        end else if (hi_cnt != 16'd0) begin
            hi_len <= hi_cnt;
            hi_cnt <= 16'd0;
        end
    end

    task automatic end_of_test();
        if (failures == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycle_cnt <= cycle_cnt + 1;
        if (cycle_cnt == 40000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        cpu_addr  = a;
        cpu_wdata = d;
        cpu_wr    = 1'b1;
        @(negedge clk);
        cpu_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(negedge clk);
        cpu_addr = a;
        cpu_rd   = 1'b1;
        @(negedge clk);
        cpu_rd = 1'b0;
        v      = {8'h00, cpu_rdata};
    endtask

    task automatic wait_irq(input int limit);
        for (int i = 0; i < limit && cpu_irq !== 1'b1; i++) @(negedge clk);
    endtask

    task automatic wait_end(output logic [15:0] v);
        v = 16'h0000;
        for (int i = 0; i < 100 && v[7] !== 1'b1; i++) begin
            cycles(10);
            rd(`CLSP_CTRL_OFFSET, v);
        end
    endtask

    task automatic t_reset();
        logic [15:0] v;
        rd(`CLSP_CTRL_OFFSET, v);
        check(v, 16'h0007);
        check({15'h0, clk_oe}, 16'h0000);
        check({15'h0, cpu_irq}, 16'h0000);
        wr(8'h0C, 8'hFF);
        rd(8'h0C, v);
        check(v, 16'h0000);
        wr(`CLSP_CTRL_OFFSET, 8'h37);
        rd(`CLSP_CTRL_OFFSET, v);
        check(v, 16'h0007);
    endtask

    task automatic t_tx_int(input logic [2:0] ss, input logic [7:0] b);
        logic [15:0] v;
        wr(`CLSP_DATA_OFFSET, b);
        wr(`CLSP_CTRL_OFFSET, {5'h0A, ss});
        wait_irq(200 << ss);
        check({8'h00, got}, {8'h00, b});
        check(hi_len, 16'd10 << ss);
        check({15'h0, clk_oe}, 16'h0001);
        check({15'h0, clk_out}, 16'h0000);
        rd(`CLSP_CTRL_OFFSET, v);
        check(v, {8'h00, 5'h18, ss});
        check({15'h0, cpu_irq}, 16'h0001);
        rd(`CLSP_DATA_OFFSET, v);
        check(v, {8'h00, b});
        check({15'h0, cpu_irq}, 16'h0000);
    endtask

    task automatic t_rx_int();
        logic [15:0] v;
        clsp_far_end_i.load(8'hA5);
        wr(`CLSP_CTRL_OFFSET, 8'h20);
        wait_end(v);
        check(v, 16'h0080);
        check({15'h0, cpu_irq}, 16'h0000);
        wr(`CLSP_CTRL_OFFSET, 8'h40);
        check({15'h0, cpu_irq}, 16'h0001);
        rd(`CLSP_DATA_OFFSET, v);
        check(v, 16'h00A5);
    endtask

    task automatic t_ext();
        logic [15:0] v;
        wr(`CLSP_DATA_OFFSET, 8'h96);
        wr(`CLSP_CTRL_OFFSET, 8'h57);
        cycles(6);
        check({15'h0, clk_oe}, 16'h0000);
        clsp_far_end_i.frame();
        wait_irq(20);
        check({8'h00, got}, 16'h0096);
        rd(`CLSP_CTRL_OFFSET, v);
        check(v, 16'h00C7);
        clsp_far_end_i.load(8'h3C);
        rd(`CLSP_DATA_OFFSET, v);
        wr(`CLSP_CTRL_OFFSET, 8'h67);
        cycles(6);
        clsp_far_end_i.frame();
        wait_irq(20);
        rd(`CLSP_DATA_OFFSET, v);
        check(v, 16'h003C);
    endtask

    task automatic t_abort_halt();
        logic [15:0] v;
        wr(`CLSP_CTRL_OFFSET, 8'h50);
        cycles(40);
        wr(`CLSP_CTRL_OFFSET, 8'h40);
        cycles(3);
        check({15'h0, clk_out}, 16'h0000);
        cycles(200);
        rd(`CLSP_CTRL_OFFSET, v);
        check(v, 16'h0040);
        wr(`CLSP_CTRL_OFFSET, 8'h50);
        wait_irq(200);
        check({15'h0, cpu_irq}, 16'h0001);
        wr(`CLSP_CTRL_OFFSET, 8'h60);
        @(negedge clk);
        io_halt_mode = 1'b1;
        @(negedge clk);
        io_halt_mode = 1'b0;
        rd(`CLSP_CTRL_OFFSET, v);
        check(v, 16'h0040);
        check({15'h0, cpu_irq}, 16'h0000);
    endtask

    task automatic t_reset_mid();
        logic [15:0] v;
        wr(`CLSP_DATA_OFFSET, 8'h5A);
        wr(`CLSP_CTRL_OFFSET, 8'h10);
        // Reset lands in the first low phase of the shift clock, before any bit has moved.
        cycles(5);
        rst_n = 1'b0;
        cycles(3);
        rst_n = 1'b1;
        check({15'h0, clk_out}, 16'h0000);
        rd(`CLSP_CTRL_OFFSET, v);
        check(v, 16'h0007);
        cycles(200);
        rd(`CLSP_CTRL_OFFSET, v);
        check(v, 16'h0007);
        rd(`CLSP_DATA_OFFSET, v);
        check(v, 16'h005A);
    endtask

    initial begin
        rst_n        = 1'b0;
        io_halt_mode = 1'b0;
        cpu_addr     = 8'h00;
        cpu_wr       = 1'b0;
        cpu_rd       = 1'b0;
        cpu_wdata    = 8'h00;
        hi_cnt       = 16'd0;
        hi_len       = 16'd0;
        failures     = 0;
        n_checks     = 0;
        cycle_cnt    = 0;
        cycles(3);
        rst_n = 1'b1;
        t_reset();
        for (int s = 0; s < 7; s++) begin
            t_tx_int(3'(s), 8'(8'h81 + s * 8'h1D));
        end
        t_rx_int();
        t_ext();
        t_abort_halt();
        t_reset_mid();
        end_of_test();
    end
endmodule
